// ===== rtl/tcc_channel_ctrl.sv
// capture/compare channel control, compare latch and interrupt vector, apb slave
// assumes: counter events arrive on pclk, capture inputs are asynchronous pins
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "tcc_defines.svh"

module tcc_channel_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] timer_count,
  input wire tcc_pkg::tcc_counter_evt_type counter_evt,
  input wire logic [4:0] other_channel_pending,
  input wire logic [3:0] capture_pin,
  output logic channel_out,
  output logic channel_equal_signal,
  output logic channel_irq,
  output logic overflow_irq,
  output logic irq
);

  // ****************************************
  // state
  // ****************************************
  tcc_pkg::tcc_ctrl_type ctrl;
  logic [15:0] channel_value_register;
  logic [15:0] compare_latch;
  logic counter_overflow_flag;
  logic overflow_irq_enable;
  logic [2:0] evt_status;
  logic [2:0] evt_mask;
  logic capture_unread;
  logic capture_wait;
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [3:0] pin_prev;
  logic rd_err;

  // ****************************************
  // bus decode
  // ****************************************
  logic setup_phase;
  logic wr_access;
  logic wr_ctrl;
  logic wr_value;
  logic wr_ovf;
  logic wr_status;
  logic wr_mask;
  logic mapped;

  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign wr_ctrl = wr_access && paddr == `TCC_OFF_CTRL;
  assign wr_value = wr_access && paddr == `TCC_OFF_VALUE;
  assign wr_ovf = wr_access && paddr == `TCC_OFF_OVF;
  assign wr_status = wr_access && paddr == `TCC_OFF_EVT_STATUS;
  assign wr_mask = wr_access && paddr == `TCC_OFF_EVT_MASK;
  assign mapped = paddr == `TCC_OFF_CTRL || paddr == `TCC_OFF_VALUE ||
    paddr == `TCC_OFF_LATCH || paddr == `TCC_OFF_VECTOR || paddr == `TCC_OFF_OVF ||
    paddr == `TCC_OFF_EVT_STATUS || paddr == `TCC_OFF_EVT_MASK;

  // read data settles in setup, so every access ends in one access cycle
  assign pready = psel && penable;
  assign pslverr = psel && penable && rd_err;

  // ****************************************
  // capture input path
  // ****************************************
  // every pin passes two flops; the async mode still loses these two cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      pin_prev <= 4'h0;
    end else begin
      pin_meta <= capture_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  logic sel_now;
  logic sel_prev;
  logic edge_seen;
  logic capture_evt;

  assign sel_now = pin_sync[ctrl.capture_input_select];
  assign sel_prev = pin_prev[ctrl.capture_input_select];

  // edge qualification by capture_edge_select
  always_comb begin
    case (ctrl.capture_edge_select)
      2'h1: edge_seen = sel_now && !sel_prev;
      2'h2: edge_seen = !sel_now && sel_prev;
      2'h3: edge_seen = sel_now != sel_prev;
      default: edge_seen = 1'b0;
    endcase
  end

  // synchronous capture waits for the next timer count step
  assign capture_evt = ctrl.snapshot_mode_select && (ctrl.sync_capture ?
    (capture_wait || edge_seen) && counter_evt.count_step : edge_seen);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_wait <= 1'b0;
    end else if (!ctrl.sync_capture || !ctrl.snapshot_mode_select) begin
      capture_wait <= 1'b0;
    end else if (counter_evt.count_step) begin
      capture_wait <= 1'b0;
    end else if (edge_seen) begin
      capture_wait <= 1'b1;
    end
  end

  // ****************************************
  // compare and latch load
  // ****************************************
  logic equal_evt;
  logic period_evt;
  logic load_evt;

  assign channel_equal_signal = timer_count == compare_latch;
  assign equal_evt = counter_evt.count_step && channel_equal_signal &&
    !ctrl.snapshot_mode_select;
  assign period_evt = counter_evt.period_match;

  always_comb begin
    case (ctrl.latch_load_select)
      tcc_pkg::TCC_LOAD_WRITE: load_evt = 1'b0;
      tcc_pkg::TCC_LOAD_ZERO: load_evt = counter_evt.count_zero;
      tcc_pkg::TCC_LOAD_ZERO_PERIOD: load_evt = counter_evt.count_zero ||
        (counter_evt.updown_mode && counter_evt.period_match);
      tcc_pkg::TCC_LOAD_LATCH: load_evt = equal_evt;
      default: load_evt = 1'b0;
    endcase
  end

  // write-moment load copies the bus data straight into the latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_latch <= `TCC_RST_WORD;
    end else if (wr_value && !ctrl.snapshot_mode_select &&
                 ctrl.latch_load_select == tcc_pkg::TCC_LOAD_WRITE) begin
      compare_latch <= pwdata[15:0];
    end else if (load_evt) begin
      compare_latch <= channel_value_register;
    end
  end

  // capture has priority over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_value_register <= `TCC_RST_WORD;
    end else if (capture_evt) begin
      channel_value_register <= timer_count;
    end else if (wr_value) begin
      channel_value_register <= pwdata[15:0];
    end
  end

  // unread capture marks when a second capture is an overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_unread <= 1'b0;
    end else if (capture_evt) begin
      capture_unread <= 1'b1;
    end else if (setup_phase && !pwrite && paddr == `TCC_OFF_VALUE) begin
      capture_unread <= 1'b0; // clears with the data latch, so no capture slips between
    end
  end

  // ****************************************
  // channel control register
  // ****************************************
  logic cov_evt;
  logic flag_evt;
  logic next_out;

  assign cov_evt = capture_evt && capture_unread;
  assign flag_evt = capture_evt || equal_evt;

  // one process owns the whole control image; hardware sets beat software writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= tcc_pkg::tcc_ctrl_type'(`TCC_RST_CTRL);
    end else begin
      if (wr_ctrl) begin
        ctrl.capture_edge_select <= pwdata[15:14];
        ctrl.capture_input_select <= pwdata[13:12];
        ctrl.sync_capture <= pwdata[11];
        ctrl.latch_load_select <= tcc_pkg::tcc_load_type'(pwdata[10:9]);
        ctrl.snapshot_mode_select <= pwdata[`TCC_POS_SNAPSHOT];
        ctrl.output_mode_select <= tcc_pkg::tcc_out_mode_type'(pwdata[7:5]);
        ctrl.channel_irq_enable <= pwdata[`TCC_POS_IRQ_EN];
      end
      ctrl.channel_input_level <= sel_now; // bus writes never reach it
      ctrl.out_bit <= next_out;
      if (flag_evt) begin
        ctrl.channel_irq_flag <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl.channel_irq_flag <= pwdata[`TCC_POS_FLAG];
      end
      if (cov_evt) begin
        ctrl.capture_overflow <= 1'b1;
      end else if (wr_ctrl && !pwdata[`TCC_POS_COV]) begin
        ctrl.capture_overflow <= 1'b0;
      end
    end
  end

  // ****************************************
  // output unit
  // ****************************************
  // equal events outrank period events, which outrank a software write
  always_comb begin
    next_out = wr_ctrl ? pwdata[`TCC_POS_OUT] : ctrl.out_bit;
    if (period_evt) begin
      case (ctrl.output_mode_select)
        tcc_pkg::TCC_OUT_TOGGLE_RESET, tcc_pkg::TCC_OUT_SET_RESET: next_out = 1'b0;
        tcc_pkg::TCC_OUT_TOGGLE_SET, tcc_pkg::TCC_OUT_RESET_SET: next_out = 1'b1;
        default: begin
        end
      endcase
    end
    if (equal_evt) begin
      case (ctrl.output_mode_select)
        tcc_pkg::TCC_OUT_SET, tcc_pkg::TCC_OUT_SET_RESET: next_out = 1'b1;
        tcc_pkg::TCC_OUT_RESET, tcc_pkg::TCC_OUT_RESET_SET: next_out = 1'b0;
        tcc_pkg::TCC_OUT_TOGGLE, tcc_pkg::TCC_OUT_TOGGLE_RESET,
        tcc_pkg::TCC_OUT_TOGGLE_SET: next_out = !ctrl.out_bit;
        default: begin
        end
      endcase
    end
  end

  assign channel_out = ctrl.out_bit;

  // ****************************************
  // counter overflow and interrupts
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_overflow_flag <= 1'b0;
      overflow_irq_enable <= 1'b0;
    end else begin
      if (counter_evt.counter_overflow) begin
        counter_overflow_flag <= 1'b1;
      end else if (wr_ovf) begin
        counter_overflow_flag <= pwdata[`TCC_POS_OVF_FLAG];
      end
      if (wr_ovf) begin
        overflow_irq_enable <= pwdata[`TCC_POS_OVF_EN];
      end
    end
  end

  assign channel_irq = ctrl.channel_irq_enable && ctrl.channel_irq_flag;
  assign overflow_irq = overflow_irq_enable && counter_overflow_flag;

  // sticky event status, write one to clear, set wins
  logic [2:0] evt_now;
  assign evt_now = {counter_evt.counter_overflow, cov_evt, flag_evt};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status <= 3'h0;
      evt_mask <= 3'h0;
    end else begin
      evt_status <= evt_now | (evt_status & ~(wr_status ? pwdata[2:0] : 3'h0));
      if (wr_mask) begin
        evt_mask <= pwdata[2:0];
      end
    end
  end

  assign irq = |(evt_status & evt_mask);

  // ****************************************
  // interrupt vector
  // ****************************************
  logic [5:0] pending;
  logic [15:0] vector_value;

  assign pending = {other_channel_pending, channel_irq};

  // lowest channel index has the highest priority, overflow last
  always_comb begin
    vector_value = `TCC_VEC_NONE;
    if (overflow_irq) begin
      vector_value = `TCC_VEC_OVF;
    end
    for (int i = 5; i >= 0; i--) begin
      if (pending[i]) begin
        vector_value = `TCC_VEC_CH1 + 16'(2 * i);
      end
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      rd_err <= 1'b0;
    end else if (setup_phase) begin
      rd_err <= !mapped;
      case (paddr)
        `TCC_OFF_CTRL: prdata <= {16'h0000, ctrl};
        `TCC_OFF_VALUE: prdata <= {16'h0000, channel_value_register};
        `TCC_OFF_LATCH: prdata <= {16'h0000, compare_latch};
        `TCC_OFF_VECTOR: prdata <= {16'h0000, vector_value};
        `TCC_OFF_OVF: prdata <= {30'h0, overflow_irq_enable, counter_overflow_flag};
        `TCC_OFF_EVT_STATUS: prdata <= {29'h0, evt_status};
        `TCC_OFF_EVT_MASK: prdata <= {29'h0, evt_mask};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ===== rtl/tcc_defines.svh
// constants for the timer capture/compare channel controller
// assumes: included by bare name into the design module, the checker and the bench
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// ****************************************
// apb byte offsets
// ****************************************
`define TCC_OFF_CTRL 8'h00
`define TCC_OFF_VALUE 8'h04
`define TCC_OFF_LATCH 8'h08
`define TCC_OFF_VECTOR 8'h0c
`define TCC_OFF_OVF 8'h10
`define TCC_OFF_EVT_STATUS 8'h14
`define TCC_OFF_EVT_MASK 8'h18

// ****************************************
// channel control field positions
// ****************************************
`define TCC_POS_FLAG 0
`define TCC_POS_COV 1
`define TCC_POS_OUT 2
`define TCC_POS_INPUT_LEVEL 3
`define TCC_POS_IRQ_EN 4
`define TCC_POS_SNAPSHOT 8

// overflow control register bits
`define TCC_POS_OVF_FLAG 0
`define TCC_POS_OVF_EN 1

// event status / mask bits
`define TCC_EVT_CHANNEL 0
`define TCC_EVT_COV 1
`define TCC_EVT_OVF 2

// ****************************************
// reset values and vector codes
// ****************************************
`define TCC_RST_CTRL 16'h0000
`define TCC_RST_WORD 16'h0000
`define TCC_VEC_NONE 16'h0000
`define TCC_VEC_CH1 16'h0002
`define TCC_VEC_OVF 16'h000e

`endif

// ===== rtl/tcc_pkg.sv
// types shared by the capture/compare channel controller
// assumes: tcc_defines.svh on the include path
package tcc_pkg;

  // output behaviour on channel equal / period events
  typedef enum logic [2:0] {
    TCC_OUT_BIT = 3'h0,
    TCC_OUT_SET = 3'h1,
    TCC_OUT_TOGGLE_RESET = 3'h2,
    TCC_OUT_SET_RESET = 3'h3,
    TCC_OUT_TOGGLE = 3'h4,
    TCC_OUT_RESET = 3'h5,
    TCC_OUT_TOGGLE_SET = 3'h6,
    TCC_OUT_RESET_SET = 3'h7
  } tcc_out_mode_type;

  // compare latch load moments
  typedef enum logic [1:0] {
    TCC_LOAD_WRITE = 2'h0,
    TCC_LOAD_ZERO = 2'h1,
    TCC_LOAD_ZERO_PERIOD = 2'h2,
    TCC_LOAD_LATCH = 2'h3
  } tcc_load_type;

  // channel control register image
  typedef struct packed {
    logic [1:0] capture_edge_select;
    logic [1:0] capture_input_select;
    logic sync_capture;
    tcc_load_type latch_load_select;
    logic snapshot_mode_select;
    tcc_out_mode_type output_mode_select;
    logic channel_irq_enable;
    logic channel_input_level;
    logic out_bit;
    logic capture_overflow;
    logic channel_irq_flag;
  } tcc_ctrl_type;

  // events from the timer counter, same clock
  typedef struct packed {
    logic count_step;
    logic count_zero;
    logic period_match;
    logic updown_mode;
    logic counter_overflow;
  } tcc_counter_evt_type;

endpackage

// ===== test/tcc_channel_ctrl_checker.sv
// checker for the channel controller apb port and interrupt vector
// assumes: bound to tcc_channel_ctrl, sees only its ports
`timescale 1ns/1ps
`include "tcc_defines.svh"

module tcc_channel_ctrl_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [4:0] other_channel_pending,
  input wire logic channel_irq,
  input wire logic overflow_irq
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic vrd;
  logic crd;
  // reads completing this cycle; vector was latched at the setup edge
  assign vrd = psel && penable && !pwrite && paddr == `TCC_OFF_VECTOR;
  assign crd = psel && penable && !pwrite && paddr == `TCC_OFF_CTRL;
  property p_ready;
    pready == (psel && penable);
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  property p_err_rd;
    pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  property p_hold;
    $changed(prdata) |-> $past(psel) && !$past(penable);
  endproperty
  property p_ctrl_hi;
    crd |-> prdata[31:16] == 16'h0;
  endproperty
  property p_ch1;
    vrd && $past(channel_irq) |-> prdata == 32'h2;
  endproperty
  property p_ch2;
    vrd && !$past(channel_irq) && $past(other_channel_pending[0]) |-> prdata == 32'h4;
  endproperty
  property p_ovf;
    vrd && !$past(channel_irq) && $past(other_channel_pending) == 5'h0 && $past(overflow_irq)
      |-> prdata == 32'he;
  endproperty
  property p_none;
    vrd && !$past(channel_irq) && $past(other_channel_pending) == 5'h0 && !$past(overflow_irq)
      |-> prdata == 32'h0;
  endproperty
  a_ready: assert property (p_ready) else $error("pready not psel and penable");
  a_err: assert property (p_err) else $error("pslverr without pready");
  a_err_rd: assert property (p_err_rd) else $error("refused read data not zero");
  a_hold: assert property (p_hold) else $error("read data moved outside setup");
  a_ctrl_hi: assert property (p_ctrl_hi) else $error("control upper bits set");
  a_ch1: assert property (p_ch1) else $error("vector not channel one");
  a_ch2: assert property (p_ch2) else $error("vector not channel two");
  a_ovf: assert property (p_ovf) else $error("vector not overflow");
  a_none: assert property (p_none) else $error("vector not empty");
  // main scenarios reached
  c_ch1: cover property (vrd && prdata == 32'h2);
  c_err: cover property (pslverr);
  c_ovf: cover property (overflow_irq && channel_irq == 1'b0);
endmodule

bind tcc_channel_ctrl tcc_channel_ctrl_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .other_channel_pending(other_channel_pending),
  .channel_irq(channel_irq), .overflow_irq(overflow_irq));

// ===== test/testbench.sv
// self-checking bench for the capture/compare channel controller
// assumes: tcc_pkg compiled first, tcc_defines.svh on the include path
`timescale 1ns/1ps
`include "tcc_defines.svh"

module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic channel_out, channel_equal_signal, channel_irq, overflow_irq, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] timer_count;
  logic [4:0] other_channel_pending;
  logic [3:0] capture_pin;
  tcc_pkg::tcc_counter_evt_type evt;
  int err_count, checks_done, cyc;

  tcc_channel_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_count(timer_count), .counter_evt(evt),
    .other_channel_pending(other_channel_pending), .capture_pin(capture_pin),
    .channel_out(channel_out), .channel_equal_signal(channel_equal_signal),
    .channel_irq(channel_irq), .overflow_irq(overflow_irq), .irq(irq));

  // ****************************************
  // clock, timeout and shared tasks
  // ****************************************
  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // hang guard, far above the few hundred cycles used
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      conclude();
    end
  end
  task automatic conclude();
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // apb master: hold request until pready seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // one-cycle counter event pulse, sampled at the second edge
  task automatic pulse(input logic [4:0] m);
    @(posedge pclk);
    evt <= tcc_pkg::tcc_counter_evt_type'(evt | m);
    @(posedge pclk);
    evt <= tcc_pkg::tcc_counter_evt_type'(evt & ~m);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // reset values and the refused address
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      rd(8'(i * 4), 32'h0);
      chk({31'h0, rerr}, {31'h0, i == 7});
    end
    apb(1'b1, 8'h1c, 32'hffff);
    chk({31'h0, rerr}, 32'h1);
  endtask
  // input level bit is read only, out bit drives pin in mode 0
  task automatic t_input();
    apb(1'b1, `TCC_OFF_CTRL, 32'h200c);
    rd(`TCC_OFF_CTRL, 32'h2004);
    chk({31'h0, channel_out}, 32'h1);
    capture_pin <= 4'h4;
    idle(4);
    rd(`TCC_OFF_CTRL, 32'h2004 | 32'h8);
    capture_pin <= 4'h0;
    apb(1'b1, `TCC_OFF_CTRL, 32'h0);
    #1;
    chk({31'h0, channel_out}, 32'h0);
  endtask
  // every output mode except bit mode 0, from both starting levels on one equal event
  task automatic t_modes();
    logic e;
    apb(1'b1, `TCC_OFF_VALUE, 32'h10);
    rd(`TCC_OFF_LATCH, 32'h10);
    chk({31'h0, channel_equal_signal}, 32'h1);
    for (int o = 0; o < 2; o++)
      for (int m = 1; m < 8; m++) begin
        apb(1'b1, `TCC_OFF_CTRL, 32'(m * 32 + o * 4));
        pulse(5'h10);
        e = (m == 1 || m == 3) ? 1'b1 : (m == 5 || m == 7) ? 1'b0 : (o == 0);
        chk({31'h0, channel_out}, {31'h0, e});
      end
  endtask
  // latch load moments: zero, zero or up/down period, equal
  task automatic t_latch();
    apb(1'b1, `TCC_OFF_CTRL, 32'h200);
    apb(1'b1, `TCC_OFF_VALUE, 32'h20);
    rd(`TCC_OFF_LATCH, 32'h10);
    pulse(5'h08);
    rd(`TCC_OFF_LATCH, 32'h20);
    apb(1'b1, `TCC_OFF_CTRL, 32'h400);
    apb(1'b1, `TCC_OFF_VALUE, 32'h30);
    pulse(5'h04);
    rd(`TCC_OFF_LATCH, 32'h20);
    pulse(5'h06);
    rd(`TCC_OFF_LATCH, 32'h30);
    apb(1'b1, `TCC_OFF_CTRL, 32'h600);
    apb(1'b1, `TCC_OFF_VALUE, 32'h40);
    pulse(5'h10);
    rd(`TCC_OFF_LATCH, 32'h30);
    timer_count <= 16'h30;
    pulse(5'h10);
    rd(`TCC_OFF_LATCH, 32'h40);
  endtask
  // edge selects, overflow stickiness, synchronised capture
  task automatic t_capture();
    for (int e = 0; e < 4; e++) begin
      apb(1'b1, `TCC_OFF_CTRL, 32'(e * 32'h4000 + 32'h1100));
      capture_pin <= 4'h2;
      idle(5);
      apb(1'b0, `TCC_OFF_CTRL, 32'h0);
      chk({31'h0, rdat[0]}, {31'h0, e[0]});
      apb(1'b0, `TCC_OFF_VALUE, 32'h0);
      apb(1'b1, `TCC_OFF_CTRL, 32'(e * 32'h4000 + 32'h1100));
      capture_pin <= 4'h0;
      idle(5);
      apb(1'b0, `TCC_OFF_CTRL, 32'h0);
      chk({31'h0, rdat[0]}, {31'h0, e[1]});
      apb(1'b0, `TCC_OFF_VALUE, 32'h0);
    end
    apb(1'b1, `TCC_OFF_CTRL, 32'h5100);
    timer_count <= 16'h1234;
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk);
      capture_pin <= 4'h2;
      idle(5);
      if (k == 0) rd(`TCC_OFF_VALUE, 32'h1234);
      @(posedge pclk);
      capture_pin <= 4'h0;
      idle(5);
    end
    rd(`TCC_OFF_CTRL, 32'h5103);
    apb(1'b0, `TCC_OFF_VALUE, 32'h0);
    idle(3);
    rd(`TCC_OFF_CTRL, 32'h5103);
    apb(1'b1, `TCC_OFF_CTRL, 32'h5900);
    rd(`TCC_OFF_CTRL, 32'h5900);
    timer_count <= 16'h4321;
    capture_pin <= 4'h2;
    idle(5);
    rd(`TCC_OFF_CTRL, 32'h5908);
    pulse(5'h10);
    rd(`TCC_OFF_CTRL, 32'h5909);
    rd(`TCC_OFF_VALUE, 32'h4321);
  endtask
  // channel and overflow requests, vector priority, event status and mask
  task automatic t_irq();
    timer_count <= 16'h40;
    apb(1'b1, `TCC_OFF_CTRL, 32'h10);
    idle(1);
    chk({31'h0, channel_irq}, 32'h0);
    pulse(5'h10);
    idle(1);
    chk({31'h0, channel_irq}, 32'h1);
    rd(`TCC_OFF_CTRL, 32'h11);
    other_channel_pending <= 5'h01;
    rd(`TCC_OFF_VECTOR, 32'h2);
    apb(1'b1, `TCC_OFF_CTRL, 32'h0);
    idle(1);
    chk({31'h0, channel_irq}, 32'h0);
    rd(`TCC_OFF_VECTOR, 32'h4);
    other_channel_pending <= 5'h10;
    rd(`TCC_OFF_VECTOR, 32'hc);
    other_channel_pending <= 5'h00;
    apb(1'b1, `TCC_OFF_OVF, 32'h2);
    apb(1'b1, `TCC_OFF_EVT_STATUS, 32'h7);
    apb(1'b1, `TCC_OFF_EVT_MASK, 32'h4);
    idle(1);
    chk({31'h0, irq}, 32'h0);
    pulse(5'h01);
    idle(1);
    chk({31'h0, overflow_irq & irq}, 32'h1);
    rd(`TCC_OFF_OVF, 32'h3);
    rd(`TCC_OFF_VECTOR, 32'he);
    apb(1'b1, `TCC_OFF_EVT_MASK, 32'h3);
    idle(1);
    chk({31'h0, irq}, 32'h0);
    rd(`TCC_OFF_EVT_STATUS, 32'h4);
    apb(1'b1, `TCC_OFF_EVT_STATUS, 32'h4);
    apb(1'b1, `TCC_OFF_EVT_MASK, 32'h4);
    apb(1'b1, `TCC_OFF_OVF, 32'h0);
    idle(1);
    chk({30'h0, irq, overflow_irq}, 32'h0);
    rd(`TCC_OFF_VECTOR, 32'h0);
  endtask

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    timer_count = 16'h0010;
    evt = '0;
    other_channel_pending = 5'h00;
    capture_pin = 4'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_input();
    t_modes();
    t_latch();
    t_capture();
    t_irq();
    conclude();
  end
endmodule
